// ==== design/vim_pkg.sv ====
package vim_pkg;

    // ==========================================
    // Sizes
    localparam int NUM_IRQ = 71;
    localparam int NUM_BITS = 96;
    localparam int NUM_FLAG_REGS = 3;
    localparam int NUM_PRIO_REGS = 18;
    localparam int OFF_LSB = 1;
    localparam int OFF_MSB = 17;
    localparam int PRIO_LSB = 2;
    localparam int SUB_LSB = 0;
    localparam int FIELD_STRIDE = 8;
    localparam int IRQ_PER_PRIO_REG = 4;

    // ==========================================
    // Source maps
    // assigned sources
    localparam logic [NUM_BITS-1:0] IRQ_ASSIGNED = 96'h0000_0071_FFE0_FFFF_C1FF_FFFF;
    localparam logic [NUM_BITS-1:0] IRQ_PERSIST = 96'h0000_0000_79E0_FE7C_0000_0000 |
                                                 96'h0000_0000_0000_0000_0031_8C60;

    // ==========================================
    // Reset values
    localparam logic [2:0] PRIO_RESET = 3'h0;
    localparam logic [1:0] SUB_RESET = 2'h0;
    localparam logic [16:0] OFF_RESET = 17'h0_0000;

    // ==========================================
    // Software access kinds
    typedef enum logic [2:0] {
        VIM_FLAG_WRITE,
        VIM_FLAG_SET,
        VIM_FLAG_CLR,
        VIM_ENABLE_WRITE,
        VIM_PRIO_WRITE,
        VIM_OFFSET_WRITE
    } vim_kind_t;

endpackage

// ==== design/vim_map.sv ====
`timescale 1ns/10ps
module vim_map
    import vim_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic sw_wr,
    input wire vim_kind_t sw_kind,
    input wire logic [6:0] sw_index,
    input wire logic [31:0] sw_wdata,
    input wire vim_kind_t rd_kind,
    input wire logic [6:0] rd_index,
    output logic [31:0] rd_data,
    input wire logic [31:0] vector_base,
    output logic core_irq,
    output logic [6:0] core_irq_num,
    output logic [2:0] core_irq_level,
    output logic [31:0] core_vector_addr
);

    // ==========================================
    // State
    // per-IRQ flag, enable, fields
    logic [NUM_BITS-1:0] flag;
    logic [NUM_BITS-1:0] enable;
    logic [NUM_IRQ-1:0] req_q;
    logic [2:0] prio [0:NUM_IRQ-1];
    logic [1:0] sub [0:NUM_IRQ-1];
    logic [16:0] offset [0:NUM_IRQ-1];

    function automatic logic [NUM_BITS-1:0] word_mask(input logic [6:0] idx, input logic [31:0] d);
        logic [NUM_BITS-1:0] m;
        m = '0;
        for (int w = 0; w < NUM_FLAG_REGS; w++)
        begin
            if (idx == 7'(w))
            begin
                m[w*32 +: 32] = d;
            end
        end
        return m;
    endfunction

    // ==========================================
    // Flag update
    wire logic [NUM_BITS-1:0] sw_word = word_mask(sw_index, sw_wdata);
    wire logic [NUM_BITS-1:0] sw_sel = word_mask(sw_index, 32'hFFFF_FFFF);
    wire logic [NUM_BITS-1:0] req_ext = {{(NUM_BITS-NUM_IRQ){1'b0}}, irq_req};
    wire logic [NUM_BITS-1:0] req_rise = {{(NUM_BITS-NUM_IRQ){1'b0}}, irq_req & ~req_q};
    wire logic [NUM_BITS-1:0] hw_set = (req_ext & IRQ_PERSIST) | (req_rise & ~IRQ_PERSIST);
    wire logic do_fw = sw_wr && sw_kind == VIM_FLAG_WRITE;
    wire logic do_fs = sw_wr && sw_kind == VIM_FLAG_SET;
    wire logic do_fc = sw_wr && sw_kind == VIM_FLAG_CLR;
    wire logic do_en = sw_wr && sw_kind == VIM_ENABLE_WRITE;
    wire logic [NUM_BITS-1:0] flag_sw = do_fw ? ((flag & ~sw_sel) | sw_word) :
                                        do_fs ? (flag | sw_word) :
                                        do_fc ? (flag & ~sw_word) : flag;
    // software set behaves as request; set beats clear; masks
    wire logic [NUM_BITS-1:0] next_flag = (flag_sw | hw_set) & IRQ_ASSIGNED;
    wire logic [NUM_BITS-1:0] next_enable = do_en ? ((enable & ~sw_sel) | sw_word) & IRQ_ASSIGNED : enable;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag <= '0;
            enable <= '0;
            req_q <= '0;
        end
        else
        begin
            flag <= next_flag;
            enable <= next_enable;
            req_q <= irq_req;
        end
    end

    // ==========================================
    // Priority and offset storage
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NUM_IRQ; i++)
            begin
                prio[i] <= PRIO_RESET;
                sub[i] <= SUB_RESET;
                offset[i] <= OFF_RESET;
            end
        end
        else if (sw_wr)
        begin
            for (int i = 0; i < NUM_IRQ; i++)
            begin
                // four IRQs share one priority register
                if (sw_kind == VIM_PRIO_WRITE && IRQ_ASSIGNED[i] &&
                    sw_index == 7'(i / IRQ_PER_PRIO_REG))
                begin
                    prio[i] <= sw_wdata[(i % IRQ_PER_PRIO_REG)*FIELD_STRIDE + PRIO_LSB +: 3];
                    sub[i] <= sw_wdata[(i % IRQ_PER_PRIO_REG)*FIELD_STRIDE + SUB_LSB +: 2];
                end
                // one offset register per vector; bits 17:1
                if (sw_kind == VIM_OFFSET_WRITE && IRQ_ASSIGNED[i] && sw_index == 7'(i))
                begin
                    offset[i] <= sw_wdata[OFF_MSB:OFF_LSB];
                end
            end
        end
    end

    // ==========================================
    // Arbitration
    logic found;
    logic [6:0] win_num;
    logic [4:0] win_key;
    always_comb
    begin
        found = 1'b0;
        win_num = '0;
        win_key = '0;
        for (int i = 0; i < NUM_IRQ; i++)
        begin
            // level 0 disables, 1..7 active, sub 0..3
            // strict compare keeps the lower IRQ on a tie
            if (flag[i] && enable[i] && prio[i] != 3'h0 && (!found || {prio[i], sub[i]} > win_key))
            begin
                found = 1'b1;
                win_num = 7'(i);
                win_key = {prio[i], sub[i]};
            end
        end
    end

    // entry point follows its own offset, no fixed stride
    wire logic [31:0] win_addr = vector_base + {14'h0000, offset[win_num], 1'b0};

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            core_irq <= 1'b0;
            core_irq_num <= '0;
            core_irq_level <= '0;
            core_vector_addr <= '0;
        end
        else
        begin
            core_irq <= found;
            core_irq_num <= win_num;
            core_irq_level <= found ? win_key[4:2] : 3'h0;
            core_vector_addr <= win_addr;
        end
    end

    // ==========================================
    // Readback
    logic [31:0] next_rd;
    always_comb
    begin
        next_rd = '0;
        unique case (rd_kind)
            VIM_FLAG_WRITE, VIM_FLAG_SET, VIM_FLAG_CLR:
            begin
                for (int w = 0; w < NUM_FLAG_REGS; w++)
                begin
                    if (rd_index == 7'(w))
                    begin
                        next_rd = flag[w*32 +: 32];
                    end
                end
            end
            VIM_ENABLE_WRITE:
            begin
                for (int w = 0; w < NUM_FLAG_REGS; w++)
                begin
                    if (rd_index == 7'(w))
                    begin
                        next_rd = enable[w*32 +: 32];
                    end
                end
            end
            VIM_PRIO_WRITE:
            begin
                // e.g. IRQ 44 lands in register 11 bits 4:0
                for (int i = 0; i < NUM_IRQ; i++)
                begin
                    if (rd_index == 7'(i / IRQ_PER_PRIO_REG))
                    begin
                        next_rd[(i % IRQ_PER_PRIO_REG)*FIELD_STRIDE + PRIO_LSB +: 3] = prio[i];
                        next_rd[(i % IRQ_PER_PRIO_REG)*FIELD_STRIDE + SUB_LSB +: 2] = sub[i];
                    end
                end
            end
            VIM_OFFSET_WRITE:
            begin
                if (rd_index < 7'(NUM_IRQ))
                begin
                    next_rd[OFF_MSB:OFF_LSB] = offset[rd_index];
                end
            end
            default:
            begin
                next_rd = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= next_rd;
        end
    end

endmodule

// ==== verif/vim_map_assertions.sv ====
`timescale 1ns/10ps
module vim_map_assertions
    import vim_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire vim_kind_t rd_kind,
    input wire logic [6:0] rd_index,
    input wire logic [31:0] rd_data,
    input wire logic [31:0] vector_base,
    input wire logic core_irq,
    input wire logic [6:0] core_irq_num,
    input wire logic [2:0] core_irq_level,
    input wire logic [31:0] core_vector_addr
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // ==========================================
    // Winner and readback checks
    a_winner_assigned: assert property (core_irq |-> IRQ_ASSIGNED[core_irq_num])
        else $error("winner is unassigned");
    a_level_nonzero: assert property (core_irq |-> core_irq_level != 3'h0)
        else $error("winner at level zero");
    a_idle_level: assert property (!core_irq |-> core_irq_level == 3'h0)
        else $error("idle level not zero");
    a_vector_even: assert property (core_irq && $stable(vector_base) |->
        ((core_vector_addr - vector_base) & 32'hFFFC_0001) == 32'h0)
        else $error("vector outside offset field");
    a_gap_reg0: assert property (rd_kind == VIM_FLAG_WRITE && rd_index == 7'h00 |=> rd_data[29:25] == 5'h00)
        else $error("unassigned flag 25..29 set");
    a_gap_reg1: assert property (rd_kind == VIM_FLAG_WRITE && rd_index == 7'h01 |=> rd_data[20:16] == 5'h00)
        else $error("unassigned flag 48..52 set");
    a_change_persist: assert property ((rd_kind == VIM_FLAG_WRITE && rd_index == 7'h01 && irq_req[44])[*2]
        |=> rd_data[12])
        else $error("port change flag not held");
    a_offset_field: assert property (rd_kind == VIM_OFFSET_WRITE |=>
        rd_data[0] == 1'b0 && rd_data[31:18] == 14'h0)
        else $error("offset bits outside 17:1");
endmodule

// ==== verif/vim_periph.sv ====
`timescale 1ns/10ps
module vim_periph
    import vim_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [NUM_IRQ-1:0] cond,
    output logic [NUM_IRQ-1:0] irq_req
);
    logic [NUM_IRQ-1:0] prev;
    // ==========================================
    // persistent sources hold a level, others pulse once
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev <= '0;
            irq_req <= '0;
        end
        else
        begin
            prev <= cond;
            irq_req <= cond & (IRQ_PERSIST[NUM_IRQ-1:0] | ~prev);
        end
    end
endmodule

// ==== verif/vim_map_bench.sv ====
`timescale 1ns/10ps
module vim_map_bench
    import vim_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [NUM_IRQ-1:0] cond = '0;
    logic [NUM_IRQ-1:0] irq_req;
    logic sw_wr = 1'b0;
    vim_kind_t sw_kind = VIM_FLAG_WRITE;
    logic [6:0] sw_index = 7'h00;
    logic [31:0] sw_wdata = 32'h0;
    vim_kind_t rd_kind = VIM_FLAG_WRITE;
    logic [6:0] rd_index = 7'h00;
    logic [31:0] rd_data;
    logic [31:0] vector_base = 32'h0001_0000;
    logic core_irq;
    logic [6:0] core_irq_num;
    logic [2:0] core_irq_level;
    logic [31:0] core_vector_addr;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int plist[7] = '{15, 16, 41, 44, 47, 59, 61};
    always #25 mclk = ~mclk;
    vim_periph i_per (.mclk, .arst_n, .cond, .irq_req);
    vim_map i_dut (.mclk, .arst_n, .irq_req, .sw_wr, .sw_kind, .sw_index, .sw_wdata, .rd_kind, .rd_index,
        .rd_data, .vector_base, .core_irq, .core_irq_num, .core_irq_level, .core_vector_addr);
    // ==========================================
    // Access tasks
    task automatic wr(input vim_kind_t k, input logic [6:0] i, input logic [31:0] d);
        @(posedge mclk);
        sw_wr <= 1'b1;
        sw_kind <= k;
        sw_index <= i;
        sw_wdata <= d;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask
    task automatic cmp_rd(input vim_kind_t k, input logic [6:0] i, input logic [31:0] e);
        @(posedge mclk);
        rd_kind <= k;
        rd_index <= i;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check_count++;
        if (rd_data !== e)
        begin
            bad_count++;
            $display("mismatch %0t read %0d got %h", $time, i, rd_data);
        end
    endtask
    task automatic cmp_core(input logic e, input logic [6:0] n, input logic [2:0] l, input logic [31:0] a);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check_count++;
        if (core_irq !== e || core_irq_level !== l || (e && (core_irq_num !== n || core_vector_addr !== a)))
        begin
            bad_count++;
            $display("mismatch %0t core got %0d", $time, core_irq_num);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Ceiling well above the fewer than 200 cycles the tests need
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        for (int r = 0; r < 3; r++)
            cmp_rd(VIM_FLAG_WRITE, 7'(r), 32'h0);
        cmp_core(1'b0, 7'h00, 3'h0, 32'h0);
        wr(VIM_ENABLE_WRITE, 7'h00, 32'h20);
        wr(VIM_PRIO_WRITE, 7'h01, 32'h0C00);
        wr(VIM_OFFSET_WRITE, 7'h05, 32'h0100);
        @(posedge mclk) cond[5] <= 1'b1;
        cmp_core(1'b1, 7'h05, 3'h3, 32'h0001_0100);
        cmp_rd(VIM_FLAG_WRITE, 7'h00, 32'h20);
        cmp_rd(VIM_OFFSET_WRITE, 7'h05, 32'h0100);
        wr(VIM_FLAG_CLR, 7'h00, 32'h20);
        cmp_rd(VIM_FLAG_WRITE, 7'h00, 32'h20);
        @(posedge mclk) cond[5] <= 1'b0;
        wr(VIM_FLAG_CLR, 7'h00, 32'h20);
        cmp_core(1'b0, 7'h00, 3'h0, 32'h0);
        $display("test walk done");
        wr(VIM_ENABLE_WRITE, 7'h00, 32'h06);
        wr(VIM_PRIO_WRITE, 7'h00, 32'h0015_1500);
        wr(VIM_OFFSET_WRITE, 7'h01, 32'h0040);
        wr(VIM_OFFSET_WRITE, 7'h02, 32'h2000);
        wr(VIM_FLAG_SET, 7'h00, 32'h06);
        cmp_core(1'b1, 7'h01, 3'h5, 32'h0001_0040);
        wr(VIM_PRIO_WRITE, 7'h00, 32'h0017_1500);
        cmp_core(1'b1, 7'h02, 3'h5, 32'h0001_2000);
        $display("test order done");
        wr(VIM_FLAG_CLR, 7'h00, 32'hFFFF_FFFF);
        foreach (plist[j])
        begin
            @(posedge mclk) cond[plist[j]] <= 1'b1;
            cmp_rd(VIM_FLAG_WRITE, 7'(plist[j] / 32), 32'h1 << (plist[j] % 32));
            wr(VIM_FLAG_CLR, 7'(plist[j] / 32), 32'hFFFF_FFFF);
            cmp_rd(VIM_FLAG_WRITE, 7'(plist[j] / 32), 32'h1 << (plist[j] % 32));
            @(posedge mclk) cond[plist[j]] <= 1'b0;
            wr(VIM_FLAG_CLR, 7'(plist[j] / 32), 32'hFFFF_FFFF);
        end
        cmp_rd(VIM_FLAG_WRITE, 7'h01, 32'h0);
        @(posedge mclk) cond[4] <= 1'b1;
        cmp_rd(VIM_FLAG_WRITE, 7'h00, 32'h10);
        wr(VIM_FLAG_CLR, 7'h00, 32'h10);
        cmp_rd(VIM_FLAG_WRITE, 7'h00, 32'h0);
        for (int r = 0; r < 3; r++)
        begin
            wr(VIM_FLAG_SET, 7'(r), 32'hFFFF_FFFF);
            cmp_rd(VIM_FLAG_WRITE, 7'(r), IRQ_ASSIGNED[32*r +: 32]);
        end
        $display("test map done");
        end_of_test();
    end
endmodule
bind vim_map vim_map_assertions i_chk (.mclk, .arst_n, .irq_req, .rd_kind, .rd_index, .rd_data, .vector_base,
    .core_irq, .core_irq_num, .core_irq_level, .core_vector_addr);
